// >>> hdl/servo_pkg.sv
// Package for the servo pulse generator: timing constants, widths and carrier structs.
// Assumes a 25 MHz system clock; every cycle count below derives from that rate.
package servo_pkg;

  // System clock rate
  localparam int unsigned CLK_HZ = 25_000_000;

  // Frame interval in microseconds, and its length in clock cycles
  localparam int unsigned FRAME_US = 20_000;
  localparam int unsigned FRAME_CYC = FRAME_US * (CLK_HZ / 1_000_000);

  // Width granularity: 0.005 ms = 5 us per step; cycles per step
  localparam int unsigned STEP_US = 5;
  localparam int unsigned STEP_CYC = STEP_US * (CLK_HZ / 1_000_000);

  // Width code in steps; a whole frame is 4000 steps, so 12 bits suffice
  localparam int unsigned WIDTH_W = 12;
  localparam int unsigned FRAME_STEPS = FRAME_US / STEP_US;

  // Counter widths; the step counter must hold STEP_CYC - 1
  localparam int unsigned STEP_CNT_W = 7;
  localparam int unsigned FRAME_CNT_W = 12;

  // Output counts of the two controllers
  localparam int unsigned CTRL1_OUTS = 3;
  localparam int unsigned CTRL2_OUTS = 2;

  // Sized constants for the logic
  localparam logic [STEP_CNT_W-1:0] STEP_LAST = STEP_CNT_W'(STEP_CYC - 1);
  localparam logic [FRAME_CNT_W-1:0] FRAME_LAST = FRAME_CNT_W'(FRAME_STEPS - 1);
  localparam logic [STEP_CNT_W-1:0] STEP_ZERO = 7'h00;
  localparam logic [FRAME_CNT_W-1:0] FRAME_ZERO = 12'h000;

  // Per-output configuration from the command side
  typedef struct packed {
    logic enable;
    logic [WIDTH_W-1:0] width;
  } chan_cfg_s;

  // Controller run state
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_RUN
  } run_e;

endpackage

// >>> hdl/servo_pulse_generator.sv
// Servo pulse generator: two controllers, three and two outputs, 20 ms frames.
// Assumes the command inputs are synchronous to i_sys_clk and held until applied.
//
// Function
// - Enabled outputs give one pulse per 20 ms frame, continuously.
// - Two controllers: first drives three outputs, second drives two.
// - Every output has its own programmable pulse width.
// - Width steps are five microseconds each.
// - Unused outputs release their pin for general purpose I/O.
// - Pulses continue alone until new widths or a stop arrive.
// - A stop request halts pulses on that controller's outputs.
// - Each controller's pins are shared with general PWM use.
`timescale 1ns/1ns

module servo_pulse_generator #(
  parameter int unsigned N1 = servo_pkg::CTRL1_OUTS,
  parameter int unsigned N2 = servo_pkg::CTRL2_OUTS,
  // Timebase: cycles per width step (at most 128) and steps per frame (at most 4096)
  parameter int unsigned STEP_CYC = servo_pkg::STEP_CYC,
  parameter int unsigned FRAME_STEPS = servo_pkg::FRAME_STEPS
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Controller 1 command: load strobe, per-output config, stop strobe
  input wire logic i_c1_load,
  input wire servo_pkg::chan_cfg_s [N1-1:0] i_c1_cfg,
  input wire logic i_c1_stop,
  // Controller 2 command
  input wire logic i_c2_load,
  input wire servo_pkg::chan_cfg_s [N2-1:0] i_c2_cfg,
  input wire logic i_c2_stop,
  // General PWM levels sharing the same pins
  input wire logic [N1-1:0] i_c1_pwm,
  input wire logic [N1-1:0] i_c1_pwm_en,
  input wire logic [N2-1:0] i_c2_pwm,
  input wire logic [N2-1:0] i_c2_pwm_en,
  // Pin drive: level and enable per output
  output logic [N1-1:0] o_ctrl1_out,
  output logic [N1-1:0] o_ctrl1_oe,
  output logic [N2-1:0] o_ctrl2_out,
  output logic [N2-1:0] o_ctrl2_oe,
  // Controller running flags
  output logic o_c1_busy,
  output logic o_c2_busy
);

  // Whole module state in one struct
  typedef struct packed {
    logic [servo_pkg::STEP_CNT_W-1:0] step_cnt;
    logic [servo_pkg::FRAME_CNT_W-1:0] frame_cnt;
    servo_pkg::run_e run1;
    servo_pkg::run_e run2;
    servo_pkg::chan_cfg_s [N1-1:0] pend1;
    servo_pkg::chan_cfg_s [N2-1:0] pend2;
    servo_pkg::chan_cfg_s [N1-1:0] act1;
    servo_pkg::chan_cfg_s [N2-1:0] act2;
    logic [N1-1:0] pulse1;
    logic [N2-1:0] pulse2;
  } state_s;

  state_s st_q;
  state_s st_d;

  // Timebase end points; a short frame keeps simulation runs practical
  localparam logic [servo_pkg::STEP_CNT_W-1:0] STEP_LAST_CNT = servo_pkg::STEP_CNT_W'(STEP_CYC - 1);
  localparam logic [servo_pkg::FRAME_CNT_W-1:0] FRAME_LAST_POS = servo_pkg::FRAME_CNT_W'(FRAME_STEPS - 1);

  // High while the frame position is inside the configured width
  function automatic logic in_pulse(input servo_pkg::chan_cfg_s c,
                                    input logic [servo_pkg::FRAME_CNT_W-1:0] pos);
    in_pulse = c.enable && (pos < c.width);
  endfunction

  logic step_end;
  logic frame_end;
  logic [servo_pkg::FRAME_CNT_W-1:0] next_pos;

  // Shared timebase: 5 us steps within a 20 ms frame; both controllers use it
  always_comb
  begin
    step_end = (st_q.step_cnt == STEP_LAST_CNT);
    frame_end = step_end && (st_q.frame_cnt == FRAME_LAST_POS);
    next_pos = st_q.frame_cnt;
    st_d = st_q;
    st_d.step_cnt = step_end ? servo_pkg::STEP_ZERO : st_q.step_cnt + 7'h01;
    if (step_end)
    begin
      next_pos = frame_end ? servo_pkg::FRAME_ZERO : st_q.frame_cnt + 12'h001;
    end
    st_d.frame_cnt = next_pos;
    // Loads are staged; a stop cancels the run at once, wins over a load
    if (i_c1_load)
    begin
      st_d.pend1 = i_c1_cfg;
      st_d.run1 = servo_pkg::ST_RUN;
    end
    if (i_c1_stop)
    begin
      st_d.run1 = servo_pkg::ST_IDLE;
    end
    if (i_c2_load)
    begin
      st_d.pend2 = i_c2_cfg;
      st_d.run2 = servo_pkg::ST_RUN;
    end
    if (i_c2_stop)
    begin
      st_d.run2 = servo_pkg::ST_IDLE;
    end
    // New widths land only on the frame boundary to avoid runt pulses
    if (frame_end)
    begin
      st_d.act1 = st_d.pend1;
      st_d.act2 = st_d.pend2;
    end
    // Pulse levels registered, computed from the next frame position
    for (int i = 0; i < N1; i++)
    begin
      st_d.pulse1[i] = (st_d.run1 == servo_pkg::ST_RUN) && in_pulse(st_d.act1[i], next_pos);
    end
    for (int i = 0; i < N2; i++)
    begin
      st_d.pulse2[i] = (st_d.run2 == servo_pkg::ST_RUN) && in_pulse(st_d.act2[i], next_pos);
    end
  end

  // Synchronous active-low reset
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Pin sharing: running servo owns all its pins and releases disabled ones; idle controller passes general PWM, else released
  always_comb
  begin
    for (int i = 0; i < N1; i++)
    begin
      if (st_q.run1 == servo_pkg::ST_RUN)
      begin
        o_ctrl1_oe[i] = st_q.act1[i].enable;
        o_ctrl1_out[i] = st_q.pulse1[i];
      end
      else
      begin
        o_ctrl1_oe[i] = i_c1_pwm_en[i];
        o_ctrl1_out[i] = i_c1_pwm[i] & i_c1_pwm_en[i];
      end
    end
    for (int i = 0; i < N2; i++)
    begin
      if (st_q.run2 == servo_pkg::ST_RUN)
      begin
        o_ctrl2_oe[i] = st_q.act2[i].enable;
        o_ctrl2_out[i] = st_q.pulse2[i];
      end
      else
      begin
        o_ctrl2_oe[i] = i_c2_pwm_en[i];
        o_ctrl2_out[i] = i_c2_pwm[i] & i_c2_pwm_en[i];
      end
    end
  end

  assign o_c1_busy = (st_q.run1 == servo_pkg::ST_RUN);
  assign o_c2_busy = (st_q.run2 == servo_pkg::ST_RUN);

  // Helper: frame start sequence
  sequence frame_start_s;
    st_q.step_cnt == servo_pkg::STEP_ZERO && st_q.frame_cnt == servo_pkg::FRAME_ZERO;
  endsequence

  // Step counter wraps at its last value
  step_wrap_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st_q.step_cnt == STEP_LAST_CNT |=> st_q.step_cnt == servo_pkg::STEP_ZERO)
    else $error("step counter did not wrap");

  // Frame position only moves on a step end
  frame_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st_q.step_cnt != STEP_LAST_CNT |=> $stable(st_q.frame_cnt))
    else $error("frame position moved mid-step");

  // Frame wraps after its last step
  frame_wrap_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    frame_end |=> frame_start_s)
    else $error("frame did not restart");

  // Controller 1 active widths change only at frame start
  width_frame_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !$stable(st_q.act1) |-> frame_start_s)
    else $error("width changed mid-frame");

  // Stop removes pulses next cycle
  stop_halts_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_c1_stop |=> !o_c1_busy ##0 st_q.pulse1 == '0)
    else $error("stop did not halt controller 1");

  // Running controller 2 pulse matches width at frame position
  pulse_shape_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_c2_busy |-> st_q.pulse2[0] == in_pulse(st_q.act2[0], st_q.frame_cnt))
    else $error("pulse level does not match width");

  // Disabled output of a running controller is released
  unused_free_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_c1_busy && !st_q.act1[0].enable |-> !o_ctrl1_oe[0])
    else $error("unused output still driven");

  // Idle controller passes general PWM through
  pwm_share_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !o_c2_busy |-> o_ctrl2_oe == i_c2_pwm_en)
    else $error("pin sharing broken");

  // Load with no stop keeps running
  load_runs_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_c2_load && !i_c2_stop |=> o_c2_busy)
    else $error("load did not start controller 2");

endmodule

// >>> sim/servo_model.sv
// Servo model: measures high time and rise-to-rise period on one pin.
// Assumes the pin level is already resolved and sampled on the system clock.
`timescale 1ns/1ns
module servo_model (
  input wire logic i_clk,
  input wire logic i_pin,
  output logic o_done,
  output logic [31:0] o_high,
  output logic [31:0] o_period
);
  logic prev_q = 1'b0;
  logic seen_q = 1'b0;
  logic [31:0] hi_q = '0;
  logic [31:0] per_q = '0;
  initial o_done = 1'b0;
  initial o_period = '0;
  // A servo reads the width only once the pulse has ended
  always @(posedge i_clk)
  begin
    prev_q <= i_pin;
    o_done <= prev_q && !i_pin;
    o_high <= hi_q;
    hi_q <= !i_pin ? 32'd0 : hi_q + 32'd1;
    per_q <= (i_pin && !prev_q) ? 32'd1 : per_q + 32'd1;
    if (i_pin && !prev_q)
    begin
      o_period <= seen_q ? per_q : 32'd0;
      seen_q <= 1'b1;
    end
  end
endmodule

// >>> sim/servo_pulse_generator_test.sv
// Testbench for the servo pulse generator, one servo model per pin.
// Assumes a shortened timebase set by parameters; runs about 10k cycles.
`timescale 1ns/1ns
module servo_pulse_generator_test;
  logic clk = 0;
  logic rst_n = 0;
  logic c1_load = 0, c1_stop = 0, c2_load = 0, c2_stop = 0;
  servo_pkg::chan_cfg_s [2:0] c1_cfg = '0;
  servo_pkg::chan_cfg_s [1:0] c2_cfg = '0;
  logic [2:0] c1_pwm = '0, c1_en = '0, o1, oe1;
  logic [1:0] c2_pwm = '0, c2_en = '0, o2, oe2;
  logic b1, b2;
  logic [4:0] pin, done;
  logic [31:0] hi [5];
  logic [31:0] per [5];
  logic [11:0] w [4];
  int fail_count = 0, comparisons = 0, n;
  int unsigned exp_q [5][$];
  // Short timebase: 4 cycles a step, 500 steps a frame
  localparam int unsigned STEP = 4;
  localparam int unsigned FSTEPS = 500;
  localparam int unsigned FRAME = STEP * FSTEPS;
  // Clock at 25 MHz
  initial forever #20 clk = ~clk;
  servo_pulse_generator #(.STEP_CYC(STEP), .FRAME_STEPS(FSTEPS))
    u_servo_pulse_generator (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_c1_load(c1_load), .i_c1_cfg(c1_cfg), .i_c1_stop(c1_stop), .i_c2_load(c2_load),
    .i_c2_cfg(c2_cfg), .i_c2_stop(c2_stop), .i_c1_pwm(c1_pwm), .i_c1_pwm_en(c1_en),
    .i_c2_pwm(c2_pwm), .i_c2_pwm_en(c2_en), .o_ctrl1_out(o1), .o_ctrl1_oe(oe1),
    .o_ctrl2_out(o2), .o_ctrl2_oe(oe2), .o_c1_busy(b1), .o_c2_busy(b2));
  // Released pins fall to the pull-down level
  assign pin = {oe2 & o2, oe1 & o1};
  for (genvar g = 0; g < 5; g++)
  begin : g_srv
    servo_model u_servo_model (.i_clk(clk), .i_pin(pin[g]), .o_done(done[g]),
      .o_high(hi[g]), .o_period(per[g]));
  end
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Note each expected width per pin for one frame
  task automatic note(input int k);
    for (int i = 0; i < 4; i++)
      exp_q[i == 2 ? 4 : (i == 3 ? 3 : i)].push_back(w[i] * STEP);
  endtask
  // Pins with the controllers idle carry the general PWM drive
  task automatic idle_pins();
    cmp("c1_out", 32'(c1_pwm & c1_en), 32'(o1));
    cmp("c2_out", 32'(c2_pwm & c2_en), 32'(o2));
    cmp("c1_oe", 32'(c1_en), 32'(oe1));
    cmp("c2_oe", 32'(c2_en), 32'(oe2));
  endtask
  // Oldest note per pin is compared whenever a pulse ends
  always @(posedge clk)
    for (int i = 0; i < 5; i++)
      if (done[i] === 1'b1)
      begin
        cmp("pulse_count", 1, 32'(exp_q[i].size() > 0));
        if (exp_q[i].size() > 0)
          cmp("pulse_width", exp_q[i].pop_front(), hi[i]);
        if (per[i] != 0)
          cmp("frame_period", FRAME, per[i]);
      end
  // Watchdog: ten frames, about twice the run time of the tests
  initial
  begin
    #(64'(FRAME) * 10 * 40);
    fail_count++;
    final_report();
  end
  // Main sequence; PWM enables opposite the levels keep the pins low
  initial
  begin
    void'($urandom(6));
    c1_pwm = 3'($urandom) | 3'h4;
    c2_pwm = 2'($urandom);
    c1_en = ~c1_pwm;
    c2_en = ~c2_pwm;
    repeat (20) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    idle_pins();
    foreach (w[i]) w[i] = 12'(160 + $urandom % 281);
    c1_cfg = {1'b0, 12'h000, 1'b1, w[1], 1'b1, 12'h0c8};
    c2_cfg = {1'b1, w[2], 1'b1, w[3]};
    c1_load = 1;
    c2_load = 1;
    @(negedge clk);
    cmp("c2_busy", 1, 32'(b2));
    c1_cfg[0].width = w[0];
    c2_load = 0;
    @(negedge clk);
    c1_load = 0;
    cmp("c1_busy", 1, 32'(b1));
    note(0);
    for (n = 0; n < 2 * FRAME && !pin[0]; n++) @(negedge clk);
    cmp("c1_oe_run", 3, 32'(oe1));
    cmp("c2_oe_run", 3, 32'(oe2));
    repeat (50) @(negedge clk);
    w[0] = 12'(160 + $urandom % 281);
    w[1] = 12'h0fa;
    c1_cfg = {1'b0, 12'h000, 1'b1, w[1], 1'b1, w[0]};
    c1_load = 1;
    @(negedge clk);
    c1_load = 0;
    note(1);
    for (n = 0; n < 3 * FRAME && exp_q[0].size() + exp_q[1].size() + exp_q[3].size() + exp_q[4].size() > 0; n++)
      @(negedge clk);
    c1_stop = 1;
    c2_stop = 1;
    @(negedge clk);
    c1_stop = 0;
    c2_stop = 0;
    cmp("c1_busy_stop", 0, 32'(b1));
    cmp("c2_busy_stop", 0, 32'(b2));
    idle_pins();
    repeat (2 * FRAME) @(negedge clk);
    cmp("pending", 0, exp_q[0].size() + exp_q[1].size() + exp_q[3].size() + exp_q[4].size());
    final_report();
  end
endmodule
